// ==== inc/pwmtb_aq_if.sv ====
`timescale 1ns/1ps
`default_nettype none
interface pwmtb_aq_if;
   import pwmtb_pkg::*;
   logic up;
   logic zero;
   logic prd;
   logic ca;
   logic cb;
   logic t1;
   logic t2;
   logic [AQ_W-1:0] cfg [2];
   pwmtb_act_t ot [2];
   pwmtb_act_t csf [2];
   logic [1:0] out;
   modport ctl (output up, zero, prd, ca, cb, t1, t2, cfg, ot, csf, input out);
   modport aq (input up, zero, prd, ca, cb, t1, t2, cfg, ot, csf, output out);
endinterface
`default_nettype wire

// ==== inc/pwmtb_pkg.sv ====
package pwmtb_pkg;
   localparam int CW = 16;
   localparam int AW = 8;
   localparam int DW = 32;
   localparam int DIVW = 11;
   localparam int NTRIG = 4;
   localparam int SYNC_LATENCY = 2;

   localparam logic [AW-1:0] ADDR_CTRL = 8'h00;
   localparam logic [AW-1:0] ADDR_PRESCALE = 8'h04;
   localparam logic [AW-1:0] ADDR_PERIOD = 8'h08;
   localparam logic [AW-1:0] ADDR_PHASE = 8'h0c;
   localparam logic [AW-1:0] ADDR_CMP_A = 8'h10;
   localparam logic [AW-1:0] ADDR_CMP_B = 8'h14;
   localparam logic [AW-1:0] ADDR_AQ_A = 8'h18;
   localparam logic [AW-1:0] ADDR_AQ_B = 8'h1c;
   localparam logic [AW-1:0] ADDR_FORCE = 8'h20;
   localparam logic [AW-1:0] ADDR_CSF = 8'h24;
   localparam logic [AW-1:0] ADDR_TRIG = 8'h28;
   localparam logic [AW-1:0] ADDR_STATUS = 8'h2c;

   // Control register fields.
   localparam int C_MODE = 0;
   localparam int C_PHS_EN = 2;
   localparam int C_DN_SYNC = 3;
   localparam int C_SYNC_EN = 4;
   localparam int C_SO_SEL = 5;
   localparam int C_PSO_SEL = 7;
   localparam int C_PRD_SHD = 9;
   localparam int C_CA_SHD = 10;
   localparam int C_CB_SHD = 11;
   localparam int C_CA_GLD = 12;
   localparam int C_CB_GLD = 13;
   localparam int C_AQ_SHD = 14;
   localparam int C_CSF_SHD = 15;
   localparam int C_EMU_STOP = 16;
   localparam int C_CA_LINK = 17;
   localparam int C_CB_LINK = 18;
   localparam int C_LD_SEL = 19;
   localparam int CTRL_W = 21;
   localparam logic [CTRL_W-1:0] CTRL_RST = 21'h000003;

   localparam int P_HSP = 0;
   localparam int P_SEC = 3;
   localparam int PRE_W = 6;
   localparam int F_SYNC = 0;
   localparam int F_GLD = 1;
   localparam int F_OT_A = 2;
   localparam int F_OT_B = 4;
   localparam int FRC_W = 6;
   localparam int S_DIR = 16;
   localparam int S_OA = 17;
   localparam int S_OB = 18;

   // Action field positions inside one output's action word.
   localparam int AQ_ZRO = 0;
   localparam int AQ_PRD = 2;
   localparam int AQ_CAU = 4;
   localparam int AQ_CAD = 6;
   localparam int AQ_CBU = 8;
   localparam int AQ_CBD = 10;
   localparam int AQ_T1U = 12;
   localparam int AQ_T1D = 14;
   localparam int AQ_T2U = 16;
   localparam int AQ_T2D = 18;
   localparam int AQ_W = 20;

   typedef enum logic [1:0] {
      ACT_NONE = 2'b00, ACT_LOW = 2'b01, ACT_HIGH = 2'b10, ACT_TOG = 2'b11
   } pwmtb_act_t;
   typedef enum logic [1:0] {
      MODE_UP = 2'b00, MODE_DOWN = 2'b01, MODE_UPDN = 2'b10, MODE_STOP = 2'b11
   } pwmtb_mode_t;
   typedef enum logic [1:0] {
      EV_NONE = 2'b00, EV_ZERO = 2'b01, EV_PRD = 2'b10, EV_BOTH = 2'b11
   } pwmtb_evsel_t;
endpackage

// ==== sim/pwm_timebase_sync_compare_action_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
`define CMP(n, e, g) begin n_compared++; if ((g) !== (e)) begin error_cnt++; \
   $display("FAIL %s exp %h got %h", n, e, g); end end
module pwm_timebase_sync_compare_action_tb import pwmtb_pkg::*;;
   typedef struct {string name; logic [31:0] val;} pwmtb_note_t;
   pwmtb_note_t note_q[$];
   pwmtb_note_t nt;
   int error_cnt = 0;
   int n_compared = 0;
   int seed = 32'h9210;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic hsel = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'b0;
   logic [31:0] hwdata = 32'h0;
   logic [31:0] hrdata;
   logic [31:0] res;
   logic hready, hresp, sync_o, psync, lwa_o, lwb_o, oa, ob, m_sync, m_lwr;
   logic sreq = 1'b0;
   logic lreq = 1'b0;
   logic [15:0] lval = 16'h0;
   logic [15:0] rv;
   logic [15:0] ldat_o, m_ldat;
   logic [3:0] dc_evt = 4'h0;
   logic [3:0] lag = 4'h0;
   logic gld = 1'b0;
   logic halt = 1'b0;
   event res_ev;

   always #5 clk = ~clk;

   pwmtb_top i_dut (.CLK_IN(clk), .RST_IN(rst), .HSEL_IN(hsel), .HADDR_IN(haddr),
      .HTRANS_IN(htrans), .HWRITE_IN(hwrite), .HSIZE_IN(3'h2), .HWDATA_IN(hwdata),
      .HREADY_IN(hready), .HRDATA_OUT(hrdata), .HREADYOUT_OUT(hready), .HRESP_OUT(hresp),
      .SYNC_IN_A_IN(m_sync), .SYNC_OUT(sync_o), .PERIPHERAL_SYNC_OUT(psync),
      .DC_EVT_IN(dc_evt), .GLOBAL_LOAD_IN(gld), .DEBUG_HALT_IN(halt),
      .LINK_WR_A_IN(m_lwr), .LINK_WR_B_IN(m_lwr), .LINK_DATA_IN(m_ldat),
      .LINK_WR_A_OUT(lwa_o), .LINK_WR_B_OUT(lwb_o), .LINK_DATA_OUT(ldat_o),
      .OUTPUT_A_OUT(oa), .OUTPUT_B_OUT(ob));

   pwmtb_chain_model i_chain (.clk(clk), .rst(rst), .lag_in(lag), .sync_req_in(sreq),
      .link_req_in(lreq), .link_val_in(lval), .sync_out(m_sync), .link_wr_out(m_lwr),
      .link_data_out(m_ldat));

   task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
      @(posedge clk);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= {24'h0, a};
      hwrite <= w;
      do @(posedge clk); while (hready !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge clk); while (hready !== 1'b1);
      res = hrdata;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      bus(a, 1'b1, d);
   endtask
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] v);
      note_q.push_back('{n, e});
      res = v;
      ->res_ev;
      // Block until the checker has taken this result, so the next one cannot overwrite it.
      wait (note_q.size() == 0);
   endtask
   task automatic rd(input logic [7:0] a, input string n, input logic [31:0] e);
      note_q.push_back('{n, e});
      bus(a, 1'b0, 32'h0);
      ->res_ev;
      wait (note_q.size() == 0);
   endtask
   task automatic pulse_sync();
      sreq <= 1'b1;
      @(posedge clk);
      sreq <= 1'b0;
      repeat (8) @(posedge clk);
   endtask
   function automatic logic pick(input int k);
      logic [3:0] v;
      v = {psync, sync_o, ob, oa};
      return v[k];
   endfunction
   // Pulse gap for the sync outputs, high time for the PWM outputs; sampled mid-cycle.
   task automatic width(input int k, input string n, input logic [31:0] e);
      logic [31:0] c;
      c = 32'h0;
      while (pick(k) !== 1'b1) @(negedge clk);
      if (k >= 2) begin
         @(negedge clk);
         c = 32'h1;
         while (pick(k) !== 1'b1) begin
            c++;
            @(negedge clk);
         end
      end else begin
         while (pick(k) === 1'b1) begin
            c++;
            @(negedge clk);
         end
      end
      chk(n, e, c);
   endtask
   task automatic summarize();
      $display("compared %0d mismatches %0d", n_compared, error_cnt);
      if (error_cnt == 0 && n_compared > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   always begin
      @(res_ev);
      nt = note_q.pop_front();
      `CMP(nt.name, nt.val, res)
   end

   initial begin
      repeat (6000) @(posedge clk);
      error_cnt++;
      summarize();
   end

   initial begin
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      repeat (2) @(posedge clk);
      rd(ADDR_CTRL, "ctrl reset", {11'h0, CTRL_RST});
      rd(8'h30, "unmapped", 32'h0);
      chk("hresp", 32'h0, {31'h0, hresp});
      repeat (3) begin
         rv = 16'($random(seed));
         wr(ADDR_CMP_A, {16'h0, rv});
         @(negedge clk);
         chk("link strobe a", 32'h1, {31'h0, lwa_o});
         @(negedge clk);
         chk("link data out", {16'h0, rv}, {16'h0, ldat_o});
         rd(ADDR_CMP_A, "cmp a", {16'h0, rv});
      end
      wr(ADDR_CTRL, 32'h3 | (32'h1 << C_CA_LINK));
      lag <= 4'h5;
      lval <= 16'h0123;
      lreq <= 1'b1;
      @(posedge clk);
      lreq <= 1'b0;
      lag <= 4'h0;
      repeat (10) @(posedge clk);
      rd(ADDR_CMP_A, "linked cmp a", 32'h0123);
      // Stopped counter, so the loaded phase can be read back exactly.
      wr(ADDR_PHASE, 32'h2a);
      wr(ADDR_CTRL, 32'h1f);
      pulse_sync();
      rd(ADDR_STATUS, "phase load", 32'h1002a);
      wr(ADDR_CTRL, 32'h0f);
      wr(ADDR_PHASE, 32'h5);
      pulse_sync();
      rd(ADDR_STATUS, "sync off", 32'h1002a);
      wr(ADDR_CTRL, 32'h17);
      wr(ADDR_PHASE, 32'h53);
      wr(ADDR_FORCE, 32'h1 << F_SYNC);
      repeat (4) @(posedge clk);
      rd(ADDR_STATUS, "forced sync up", 32'h10053);
      wr(ADDR_AQ_A, 32'h2 << AQ_T1U);
      wr(ADDR_TRIG, 32'h2);
      dc_evt <= 4'h4;
      @(posedge clk);
      dc_evt <= 4'h0;
      repeat (3) @(negedge clk);
      chk("trigger a", 32'h1, {31'h0, oa});
      wr(ADDR_FORCE, 32'h1 << F_OT_A);
      repeat (3) @(negedge clk);
      chk("one-time low", 32'h0, {31'h0, oa});
      wr(ADDR_CSF, 32'h2);
      repeat (3) @(negedge clk);
      chk("continuous high", 32'h1, {31'h0, oa});
      wr(ADDR_CSF, 32'h0);
      wr(ADDR_AQ_A, (32'h2 << AQ_CAU) | (32'h1 << AQ_CAD));
      wr(ADDR_AQ_B, (32'h2 << AQ_CBU) | (32'h1 << AQ_CBD));
      wr(ADDR_PERIOD, 32'ha);
      wr(ADDR_CMP_A, 32'h4);
      wr(ADDR_CMP_B, 32'h7);
      @(negedge clk);
      chk("link strobe b", 32'h1, {31'h0, lwb_o});
      wr(ADDR_CTRL, 32'h122);
      width(2, "sync gap", 32'd20);
      width(0, "a high", 32'd12);
      width(1, "b high", 32'd6);
      width(3, "peripheral gap", 32'd20);
      wr(ADDR_CTRL, 32'h222);
      wr(ADDR_PERIOD, 32'h6);
      rd(ADDR_PERIOD, "period shadow", 32'h6);
      width(2, "shadow gap", 32'd12);
      wr(ADDR_PRESCALE, 32'h1);
      repeat (30) @(posedge clk);
      width(2, "prescaled gap", 32'd24);
      wr(ADDR_CTRL, 32'h220);
      repeat (30) @(posedge clk);
      width(2, "up mode gap", 32'd14);
      wr(ADDR_CTRL, 32'h221);
      repeat (30) @(posedge clk);
      width(2, "down mode gap", 32'd14);
      wr(ADDR_CTRL, 32'h81620);
      wr(ADDR_CMP_A, 32'h3);
      repeat (30) @(posedge clk);
      rd(ADDR_CMP_A, "cmp a held", 32'h4);
      gld <= 1'b1;
      @(posedge clk);
      gld <= 1'b0;
      repeat (30) @(posedge clk);
      rd(ADDR_CMP_A, "cmp a global", 32'h3);
      wr(ADDR_CTRL, 32'h10220);
      halt <= 1'b1;
      repeat (10) @(posedge clk);
      bus(ADDR_STATUS, 1'b0, 32'h0);
      rv = res[15:0];
      repeat (10) @(posedge clk);
      bus(ADDR_STATUS, 1'b0, 32'h0);
      chk("halt hold", {16'h0, rv}, {16'h0, res[15:0]});
      halt <= 1'b0;
      wr(ADDR_CTRL, 32'h0e);
      wr(ADDR_FORCE, 32'h1 << F_SYNC);
      bus(ADDR_STATUS, 1'b0, 32'h0);
      chk("sync down", 32'h0, {31'h0, res[S_DIR]});
      summarize();
   end
endmodule // pwm_timebase_sync_compare_action_tb
`default_nettype wire

// ==== sim/pwmtb_chain_model.sv ====
`timescale 1ns/1ps
`default_nettype none
// First channel of the chain: sends sync pulses and linked compare writes lag_in+1 cycles after each request.
module pwmtb_chain_model (
   input wire logic clk,
   input wire logic rst,
   input wire logic [3:0] lag_in,
   input wire logic sync_req_in,
   input wire logic link_req_in,
   input wire logic [15:0] link_val_in,
   output logic sync_out,
   output logic link_wr_out,
   output logic [15:0] link_data_out
);
   logic [15:0] s_sh;
   logic [15:0] l_sh;
   logic [15:0] val_q;
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         s_sh <= 16'h0;
         l_sh <= 16'h0;
         val_q <= 16'h0;
      end else begin
         s_sh <= {s_sh[14:0], sync_req_in};
         l_sh <= {l_sh[14:0], link_req_in};
         if (link_req_in) begin
            val_q <= link_val_in;
         end
      end
   end
   assign sync_out = s_sh[lag_in];
   assign link_wr_out = l_sh[lag_in];
   // Outside the strobe the data bus carries junk, so a sloppy receiver cannot pass.
   assign link_data_out = link_wr_out ? val_q : ~val_q;
endmodule // pwmtb_chain_model
`default_nettype wire

// ==== src/pwmtb_aq.sv ====
`timescale 1ns/1ps
`default_nettype none
module pwmtb_aq import pwmtb_pkg::*; (
   input wire logic clk,
   input wire logic rst,
   pwmtb_aq_if.aq aq
);
   logic [1:0] out_q;
   logic [1:0] out_d;
   pwmtb_act_t act [2];

   function automatic pwmtb_act_t pick(pwmtb_act_t cur, logic ev, logic [1:0] code);
      pick = (ev && code != ACT_NONE) ? pwmtb_act_t'(code) : cur;
   endfunction

   // Later events in the chain take priority over earlier ones.
   always_comb begin
      for (int i = 0; i < 2; i++) begin
         act[i] = ACT_NONE;
         act[i] = pick(act[i], aq.zero, aq.cfg[i][AQ_ZRO+:2]);
         act[i] = pick(act[i], aq.prd, aq.cfg[i][AQ_PRD+:2]);
         act[i] = pick(act[i], aq.ca, aq.up ? aq.cfg[i][AQ_CAU+:2] : aq.cfg[i][AQ_CAD+:2]);
         act[i] = pick(act[i], aq.cb, aq.up ? aq.cfg[i][AQ_CBU+:2] : aq.cfg[i][AQ_CBD+:2]);
         act[i] = pick(act[i], aq.t1, aq.up ? aq.cfg[i][AQ_T1U+:2] : aq.cfg[i][AQ_T1D+:2]);
         act[i] = pick(act[i], aq.t2, aq.up ? aq.cfg[i][AQ_T2U+:2] : aq.cfg[i][AQ_T2D+:2]);
         act[i] = pick(act[i], 1'b1, aq.ot[i]);
         // A continuous force beats everything; toggle is not a steady level.
         if (aq.csf[i] == ACT_LOW || aq.csf[i] == ACT_HIGH) begin
            act[i] = aq.csf[i];
         end
         unique case (act[i])
            ACT_NONE: out_d[i] = out_q[i];
            ACT_LOW: out_d[i] = 1'b0;
            ACT_HIGH: out_d[i] = 1'b1;
            ACT_TOG: out_d[i] = ~out_q[i];
         endcase
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         out_q <= 2'h0;
      end else begin
         out_q <= out_d;
      end
   end

   assign aq.out = out_q;

   a_cmp_up_set: assert property (@(posedge clk) disable iff (rst)
      (aq.ca && aq.up && aq.cfg[0][AQ_CAU+:2] == ACT_HIGH && !aq.t1 && !aq.t2
       && aq.ot[0] == ACT_NONE && aq.csf[0] == ACT_NONE) |=> aq.out[0])
      else $error("Output A not set on up compare match.");
   a_csf_low: assert property (@(posedge clk) disable iff (rst)
      (aq.csf[1] == ACT_LOW) |=> !aq.out[1])
      else $error("Continuous force low not applied to output B.");
   c_cmp_down: cover property (@(posedge clk) disable iff (rst) aq.ca && !aq.up);
endmodule // pwmtb_aq
`default_nettype wire

// ==== src/pwmtb_top.sv ====
// The address map and the AHB-Lite interface to the registers were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module pwmtb_top import pwmtb_pkg::*; (
   input wire logic CLK_IN,
   input wire logic RST_IN,
   input wire logic HSEL_IN,
   input wire logic [31:0] HADDR_IN,
   input wire logic [1:0] HTRANS_IN,
   input wire logic HWRITE_IN,
   input wire logic [2:0] HSIZE_IN,
   input wire logic [DW-1:0] HWDATA_IN,
   input wire logic HREADY_IN,
   output logic [DW-1:0] HRDATA_OUT,
   output logic HREADYOUT_OUT,
   output logic HRESP_OUT,
   input wire logic SYNC_IN_A_IN,
   output logic SYNC_OUT,
   output logic PERIPHERAL_SYNC_OUT,
   input wire logic [NTRIG-1:0] DC_EVT_IN,
   input wire logic GLOBAL_LOAD_IN,
   input wire logic DEBUG_HALT_IN,
   input wire logic LINK_WR_A_IN,
   input wire logic LINK_WR_B_IN,
   input wire logic [CW-1:0] LINK_DATA_IN,
   output logic LINK_WR_A_OUT,
   output logic LINK_WR_B_OUT,
   output logic [CW-1:0] LINK_DATA_OUT,
   output logic OUTPUT_A_OUT,
   output logic OUTPUT_B_OUT
);
   logic [AW-1:0] addr_q, addr_d;
   logic wr_q, wr_d, act_q, act_d;
   logic [DW-1:0] rdata_q, rdata_d;
   logic [CTRL_W-1:0] ctrl_q, ctrl_d;
   logic [PRE_W-1:0] pre_q, pre_d;
   logic [CW-1:0] prd_q, prd_d, prd_sh_q, prd_sh_d, phs_q, phs_d;
   logic [CW-1:0] ca_q, ca_d, ca_sh_q, ca_sh_d, cb_q, cb_d, cb_sh_q, cb_sh_d;
   logic [AQ_W-1:0] aqa_q, aqa_d, aqa_sh_q, aqa_sh_d, aqb_q, aqb_d, aqb_sh_q, aqb_sh_d;
   logic [3:0] csf_q, csf_d, csf_sh_q, csf_sh_d, trig_q, trig_d;
   logic [FRC_W-1:0] frc_q, frc_d;
   logic gld_q, gld_d, lwa_q, lwa_d, lwb_q, lwb_d;
   logic [CW-1:0] ldat_q, ldat_d;
   logic [CW-1:0] cnt_q, cnt_d;
   logic [DIVW-1:0] div_q, div_d;
   logic up_q, up_d, halt_q, halt_d, so_q, so_d, pso_q, pso_d;
   logic wen, tick_raw, step, sync_acc, ev_zero, ev_prd, ev_ca, ev_cb, ld_evt;
   logic wa, wb;
   logic [CW-1:0] wa_dat, wb_dat;
   pwmtb_mode_t mode;

   function automatic logic [DIVW-1:0] div_len(logic [PRE_W-1:0] p);
      logic [DIVW-1:0] h;
      logic [DIVW-1:0] s;
      h = (p[P_HSP+:3] == 3'h0) ? DIVW'(1) : DIVW'({p[P_HSP+:3], 1'b0});
      s = DIVW'(1) << p[P_SEC+:3];
      div_len = DIVW'(h * s);
   endfunction

   function automatic logic ev_sel(logic [1:0] sel, logic z, logic p);
      ev_sel = (sel[0] && z) || (sel[1] && p);
   endfunction

   assign mode = pwmtb_mode_t'(ctrl_q[C_MODE+:2]);
   assign wen = act_q && wr_q;
   assign tick_raw = (div_q == div_len(pre_q) - DIVW'(1));
   assign step = tick_raw && !halt_q && mode != MODE_STOP;
   assign sync_acc = (ctrl_q[C_SYNC_EN] && SYNC_IN_A_IN) || frc_q[F_SYNC];
   assign ev_zero = step && cnt_q == '0;
   assign ev_prd = step && cnt_q == prd_q;
   assign ev_ca = step && cnt_q == ca_q;
   assign ev_cb = step && cnt_q == cb_q;
   assign ld_evt = ev_sel(ctrl_q[C_LD_SEL+:2], ev_zero, ev_prd);
   // The bus wins over a linked write that lands in the same cycle.
   assign wa = (wen && addr_q == ADDR_CMP_A) || (ctrl_q[C_CA_LINK] && LINK_WR_A_IN);
   assign wb = (wen && addr_q == ADDR_CMP_B) || (ctrl_q[C_CB_LINK] && LINK_WR_B_IN);
   assign wa_dat = (wen && addr_q == ADDR_CMP_A) ? HWDATA_IN[CW-1:0] : LINK_DATA_IN;
   assign wb_dat = (wen && addr_q == ADDR_CMP_B) ? HWDATA_IN[CW-1:0] : LINK_DATA_IN;

   // Zero-wait slave: read data is fetched in the address phase.
   always_comb begin
      act_d = HSEL_IN && HTRANS_IN[1] && HREADY_IN;
      addr_d = act_d ? HADDR_IN[AW-1:0] : addr_q;
      wr_d = act_d && HWRITE_IN;
      rdata_d = rdata_q;
      if (act_d && !HWRITE_IN) begin
         unique case (HADDR_IN[AW-1:0])
            ADDR_CTRL: rdata_d = DW'(ctrl_q);
            ADDR_PRESCALE: rdata_d = DW'(pre_q);
            ADDR_PERIOD: rdata_d = DW'(ctrl_q[C_PRD_SHD] ? prd_sh_q : prd_q);
            ADDR_PHASE: rdata_d = DW'(phs_q);
            ADDR_CMP_A: rdata_d = DW'(ca_q);
            ADDR_CMP_B: rdata_d = DW'(cb_q);
            ADDR_AQ_A: rdata_d = DW'(aqa_q);
            ADDR_AQ_B: rdata_d = DW'(aqb_q);
            ADDR_CSF: rdata_d = DW'(csf_q);
            ADDR_TRIG: rdata_d = DW'(trig_q);
            ADDR_STATUS: rdata_d = DW'({OUTPUT_B_OUT, OUTPUT_A_OUT, up_q, cnt_q});
            default: rdata_d = '0;
         endcase
      end
   end

   always_ff @(posedge CLK_IN or posedge RST_IN) begin
      if (RST_IN) begin
         act_q <= 1'b0;
         wr_q <= 1'b0;
         addr_q <= '0;
         rdata_q <= '0;
         HREADYOUT_OUT <= 1'b0;
         HRESP_OUT <= 1'b0;
      end else begin
         act_q <= act_d;
         wr_q <= wr_d;
         addr_q <= addr_d;
         rdata_q <= rdata_d;
         HREADYOUT_OUT <= 1'b1;
         HRESP_OUT <= 1'b0;
      end
   end
   assign HRDATA_OUT = rdata_q;

   // Configuration, shadows and global load.
   always_comb begin
      ctrl_d = ctrl_q;
      pre_d = pre_q;
      prd_d = prd_q;
      prd_sh_d = prd_sh_q;
      phs_d = phs_q;
      aqa_sh_d = aqa_sh_q;
      aqb_sh_d = aqb_sh_q;
      csf_sh_d = csf_sh_q;
      trig_d = trig_q;
      frc_d = '0;
      if (wen) begin
         unique case (addr_q)
            ADDR_CTRL: ctrl_d = HWDATA_IN[CTRL_W-1:0];
            ADDR_PRESCALE: pre_d = HWDATA_IN[PRE_W-1:0];
            ADDR_PERIOD: prd_sh_d = HWDATA_IN[CW-1:0];
            ADDR_PHASE: phs_d = HWDATA_IN[CW-1:0];
            ADDR_AQ_A: aqa_sh_d = HWDATA_IN[AQ_W-1:0];
            ADDR_AQ_B: aqb_sh_d = HWDATA_IN[AQ_W-1:0];
            ADDR_CSF: csf_sh_d = HWDATA_IN[3:0];
            ADDR_TRIG: trig_d = HWDATA_IN[3:0];
            ADDR_FORCE: frc_d = HWDATA_IN[FRC_W-1:0];
            default: ;
         endcase
      end
      if (!ctrl_q[C_PRD_SHD] || ev_zero) begin
         prd_d = prd_sh_d;
      end
      aqa_d = (!ctrl_q[C_AQ_SHD] || ld_evt) ? aqa_sh_d : aqa_q;
      aqb_d = (!ctrl_q[C_AQ_SHD] || ld_evt) ? aqb_sh_d : aqb_q;
      csf_d = (!ctrl_q[C_CSF_SHD] || ld_evt) ? csf_sh_d : csf_q;
      // A new global load request wins over the load event that consumes one.
      gld_d = GLOBAL_LOAD_IN || frc_q[F_GLD] || (gld_q && !ld_evt);
      ca_sh_d = wa ? wa_dat : ca_sh_q;
      cb_sh_d = wb ? wb_dat : cb_sh_q;
      ca_d = ca_q;
      cb_d = cb_q;
      if (!ctrl_q[C_CA_SHD]) begin
         ca_d = ca_sh_d;
      end else if (ld_evt && (!ctrl_q[C_CA_GLD] || gld_q)) begin
         ca_d = ca_sh_q;
      end
      if (!ctrl_q[C_CB_SHD]) begin
         cb_d = cb_sh_d;
      end else if (ld_evt && (!ctrl_q[C_CB_GLD] || gld_q)) begin
         cb_d = cb_sh_q;
      end
      lwa_d = wen && addr_q == ADDR_CMP_A;
      lwb_d = wen && addr_q == ADDR_CMP_B;
      ldat_d = (lwa_d || lwb_d) ? HWDATA_IN[CW-1:0] : ldat_q;
   end

   always_ff @(posedge CLK_IN or posedge RST_IN) begin
      if (RST_IN) begin
         ctrl_q <= CTRL_RST;
         pre_q <= '0;
         {prd_q, prd_sh_q, phs_q, ca_q, ca_sh_q, cb_q, cb_sh_q} <= '0;
         {aqa_q, aqa_sh_q, aqb_q, aqb_sh_q} <= '0;
         {csf_q, csf_sh_q, trig_q} <= '0;
         frc_q <= '0;
         {gld_q, lwa_q, lwb_q} <= 3'h0;
         ldat_q <= '0;
      end else begin
         ctrl_q <= ctrl_d;
         pre_q <= pre_d;
         {prd_q, prd_sh_q, phs_q, ca_q, ca_sh_q, cb_q, cb_sh_q} <=
            {prd_d, prd_sh_d, phs_d, ca_d, ca_sh_d, cb_d, cb_sh_d};
         {aqa_q, aqa_sh_q, aqb_q, aqb_sh_q} <= {aqa_d, aqa_sh_d, aqb_d, aqb_sh_d};
         {csf_q, csf_sh_q, trig_q} <= {csf_d, csf_sh_d, trig_d};
         frc_q <= frc_d;
         {gld_q, lwa_q, lwb_q} <= {gld_d, lwa_d, lwb_d};
         ldat_q <= ldat_d;
      end
   end
   assign LINK_WR_A_OUT = lwa_q;
   assign LINK_WR_B_OUT = lwb_q;
   assign LINK_DATA_OUT = ldat_q;

   // Time base. Sync is taken on the cycle it arrives, which together with the
   // registered sync output of the source gives the chain its fixed latency.
   always_comb begin
      div_d = tick_raw ? '0 : div_q + DIVW'(1);
      halt_d = DEBUG_HALT_IN && ctrl_q[C_EMU_STOP] && (halt_q || tick_raw);
      cnt_d = cnt_q;
      up_d = up_q;
      if (sync_acc && ctrl_q[C_PHS_EN]) begin
         cnt_d = phs_q;
         if (mode == MODE_UPDN) begin
            up_d = !ctrl_q[C_DN_SYNC];
         end
      end else if (step) begin
         unique case (mode)
            MODE_UP: begin
               up_d = 1'b1;
               cnt_d = (cnt_q >= prd_q) ? '0 : cnt_q + CW'(1);
            end
            MODE_DOWN: begin
               up_d = 1'b0;
               cnt_d = (cnt_q == '0) ? prd_q : cnt_q - CW'(1);
            end
            MODE_UPDN: begin
               if (up_q && cnt_q >= prd_q) begin
                  up_d = 1'b0;
                  cnt_d = (cnt_q == '0) ? cnt_q : cnt_q - CW'(1);
               end else if (!up_q && cnt_q == '0) begin
                  up_d = 1'b1;
                  cnt_d = cnt_q + CW'(1);
               end else begin
                  cnt_d = up_q ? cnt_q + CW'(1) : cnt_q - CW'(1);
               end
            end
            MODE_STOP: cnt_d = cnt_q;
         endcase
      end
      so_d = ev_sel(ctrl_q[C_SO_SEL+:2], ev_zero, ev_prd);
      pso_d = ev_sel(ctrl_q[C_PSO_SEL+:2], ev_zero, ev_prd);
   end

   always_ff @(posedge CLK_IN or posedge RST_IN) begin
      if (RST_IN) begin
         div_q <= '0;
         halt_q <= 1'b0;
         cnt_q <= '0;
         up_q <= 1'b1;
         so_q <= 1'b0;
         pso_q <= 1'b0;
      end else begin
         div_q <= div_d;
         halt_q <= halt_d;
         cnt_q <= cnt_d;
         up_q <= up_d;
         so_q <= so_d;
         pso_q <= pso_d;
      end
   end
   assign SYNC_OUT = so_q;
   assign PERIPHERAL_SYNC_OUT = pso_q;

   pwmtb_aq_if aqi ();
   assign aqi.up = up_q;
   assign aqi.zero = ev_zero;
   assign aqi.prd = ev_prd;
   assign aqi.ca = ev_ca;
   assign aqi.cb = ev_cb;
   assign aqi.t1 = DC_EVT_IN[trig_q[1:0]];
   assign aqi.t2 = DC_EVT_IN[trig_q[3:2]];
   assign aqi.cfg[0] = aqa_q;
   assign aqi.cfg[1] = aqb_q;
   assign aqi.ot[0] = pwmtb_act_t'(frc_q[F_OT_A+:2]);
   assign aqi.ot[1] = pwmtb_act_t'(frc_q[F_OT_B+:2]);
   assign aqi.csf[0] = pwmtb_act_t'(csf_q[1:0]);
   assign aqi.csf[1] = pwmtb_act_t'(csf_q[3:2]);

   pwmtb_aq u_aq (
      .clk(CLK_IN),
      .rst(RST_IN),
      .aq(aqi.aq)
   );
   assign OUTPUT_A_OUT = aqi.out[0];
   assign OUTPUT_B_OUT = aqi.out[1];

   default clocking cb_main @(posedge CLK_IN); endclocking
   default disable iff (RST_IN);

   a_sync_zero: assert property (
      (step && cnt_q == '0 && ctrl_q[C_SO_SEL+:2] == EV_ZERO) |=> SYNC_OUT)
      else $error("Sync output missing after counter zero.");
   a_phase_load: assert property (
      (sync_acc && ctrl_q[C_PHS_EN]) |=> cnt_q == $past(phs_q))
      else $error("Counter not loaded with phase on sync.");
   a_sync_dir: assert property (
      (sync_acc && ctrl_q[C_PHS_EN] && mode == MODE_UPDN && ctrl_q[C_DN_SYNC]) |=> !up_q)
      else $error("Counter not counting down after sync.");
   a_updn_top: assert property (
      (step && !sync_acc && mode == MODE_UPDN && up_q && cnt_q == prd_q && prd_q != '0)
      |=> (!up_q && cnt_q == $past(cnt_q) - CW'(1)))
      else $error("Up-down counter did not turn at period.");
   a_updn_bottom: assert property (
      (step && !sync_acc && mode == MODE_UPDN && !up_q && cnt_q == '0)
      |=> (up_q && cnt_q == CW'(1)))
      else $error("Up-down counter did not turn at zero.");
   a_up_wrap: assert property (
      (step && !sync_acc && mode == MODE_UP && cnt_q == prd_q) |=> cnt_q == '0)
      else $error("Up counter did not wrap after period.");
   a_halt_hold: assert property (
      (halt_q && !sync_acc) |=> cnt_q == $past(cnt_q))
      else $error("Counter moved while halted.");
   a_prd_load: assert property (
      (ctrl_q[C_PRD_SHD] && ev_zero && !wen) |=> prd_q == $past(prd_sh_q))
      else $error("Period shadow not loaded at zero.");
   a_div_gap: assert property (
      (tick_raw && div_len(pre_q) > DIVW'(1) && !wen) |=> !tick_raw)
      else $error("Prescaled tick came too early.");
   c_sync_load: cover property (sync_acc && ctrl_q[C_PHS_EN]);
   c_updn_turn: cover property (ev_prd && mode == MODE_UPDN);
   c_halted: cover property (halt_q);
   c_global: cover property (gld_q && ld_evt && ctrl_q[C_CA_GLD]);
endmodule // pwmtb_top
`default_nettype wire
